// File: core/sarc_pkg.sv
// Shared constants, register map and carrier types of the converter sequencer
package sarc_pkg;
  // Clock and conversion timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CONV12_NS = 400;
  localparam int unsigned CONV12_CYC = (CONV12_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SMP_CYC = 4;
  localparam int unsigned PWRUP_CYC = 8;
  localparam int unsigned CNT_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_ISR = 8'h00;
  localparam logic [7:0] OFS_IER = 8'h04;
  localparam logic [7:0] OFS_CR = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h0c;
  localparam logic [7:0] OFS_CHSEL = 8'h10;
  localparam logic [7:0] OFS_AWD1 = 8'h14;
  localparam logic [7:0] OFS_AWD2 = 8'h18;
  localparam logic [7:0] OFS_AWD3 = 8'h1c;
  localparam logic [7:0] OFS_DR = 8'h20;
  localparam logic [7:0] OFS_SR = 8'h24;

  // Control register bits
  localparam int unsigned CR_EN = 0;
  localparam int unsigned CR_START = 1;
  localparam int unsigned CR_AWDEN = 4;

  // Channel map: 7 external, 3 internal, rest reserved
  localparam int unsigned CH_NUM = 19;
  localparam int unsigned CH_W = 5;
  localparam int unsigned CH_TEMP = 12;
  localparam int unsigned CH_VREF = 13;
  localparam int unsigned CH_VCORE = 14;
  localparam logic [18:0] CH_VALID = 19'h0007f | (19'h1 << CH_TEMP) | (19'h1 << CH_VREF)
                                     | (19'h1 << CH_VCORE);

  // Resolution codes
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_8 = 2'h2;
  localparam logic [1:0] RES_6 = 2'h3;
  localparam logic [11:0] RAW_FULL = 12'hfff;

  // Trigger polarity codes
  localparam logic [1:0] POL_RISE = 2'h0;
  localparam logic [1:0] POL_FALL = 2'h1;

  localparam int unsigned EVT_W = 7;
  localparam int unsigned ACC_W = 20;

  typedef struct packed {
    logic [9:0] rsv;
    logic [3:0] ovs_shift;
    logic [2:0] ovs_ratio;
    logic ovs_en;
    logic dma_en;
    logic [1:0] trig_pol;
    logic [2:0] trig_sel;
    logic autoff;
    logic waitm;
    logic disc;
    logic scan;
    logic cont;
    logic align;
    logic [1:0] res;
  } sarc_cfg_t;

  typedef struct packed {
    logic [3:0] rsv1;
    logic [11:0] hi;
    logic [3:0] rsv0;
    logic [11:0] lo;
  } sarc_thr_t;

  typedef struct packed {
    logic awd3;
    logic awd2;
    logic awd1;
    logic ovr;
    logic eos;
    logic eoc;
    logic eosmp;
  } sarc_evt_t;

  typedef struct packed {
    logic pwr;
    logic sample;
    logic conv;
    logic [1:0] res;
    logic [4:0] chan;
  } sarc_ana_t;

  typedef enum logic [1:0] {SARC_IDLE, SARC_PWRUP, SARC_SMP, SARC_CONV} sarc_state_t;

  // Result width for a resolution code
  function automatic logic [4:0] sarc_bits(input logic [1:0] res);
    return 5'(12 - 2 * int'(res));
  endfunction

  // Conversion phase length, shorter at lower resolution
  function automatic logic [7:0] sarc_conv_cyc(input logic [1:0] res);
    return 8'(CONV12_CYC * int'(sarc_bits(res)) / 12);
  endfunction
endpackage

// File: core/sarc_wdog.sv
// Window comparator of one analog watchdog
`timescale 1ns/1ps
module sarc_wdog (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic en,
  input wire logic stb,
  input wire logic [11:0] val,
  input wire sarc_pkg::sarc_thr_t thr,
  output logic trip
);
  logic trip_ff;

  // One-cycle trip when a fresh value leaves the window
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      trip_ff <= 1'b0;
    end else begin
      trip_ff <= en && stb && (val > thr.hi || val < thr.lo);
    end
  end

  assign trip = trip_ff;
endmodule

// File: core/sarc_top.sv
// Sequencer and register file of the successive-approximation converter
// Function
// - Result resolution selectable as 12, 10, 8 or 6 bits.
// - Nineteen channel positions: seven external, three internal, rest reserved.
// - Internal channels carry temperature sense, internal reference and core supply.
// - Single channel, scanned sequence, continuous and discontinuous operation.
// - Single mode converts the selection once per trigger, then waits.
// - Continuous mode repeats the selection without new triggers.
// - Result lands in a 16-bit data register, left or right aligned.
// - Start by software or selectable hardware trigger with chosen polarity.
// - Three watchdogs flag values outside an upper/lower threshold window.
// - Oversampler accumulates up to 256 conversions into one result.
// - 12-bit conversion takes 0.4 us; lower resolution converts faster.
// - Wait mode holds the next conversion until the result is read.
// - Auto-off powers the analog core only while converting.
// - Autonomous in stop: trigger powers up, converts, hands to DMA, powers down.
// - Sampling, conversion, sequence, watchdog and overrun events interrupt and wake.
// - Interrupts wake the device from both deeper stop states.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module sarc_top #(
  parameter int unsigned TRIG_N = 4
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TRIG_N-1:0] hw_trig,
  input wire logic stop_mode,
  input wire logic [11:0] ana_data,
  output sarc_pkg::sarc_ana_t ana,
  output logic dma_req,
  input wire logic dma_ack,
  output logic [15:0] dma_data,
  output logic irq,
  output logic wakeup
);
  // Local copies of package widths, usable as cast sizes
  localparam int unsigned ACC_W_L = sarc_pkg::ACC_W;
  localparam int unsigned CNT_W_L = sarc_pkg::CNT_W;
  sarc_pkg::sarc_state_t state_ff, nxt_state;
  logic [sarc_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  sarc_pkg::sarc_cfg_t cfg_ff;
  sarc_pkg::sarc_thr_t thr_ff [3];
  sarc_pkg::sarc_evt_t isr_ff, ier_ff, evt_set;
  logic [18:0] chsel_ff;
  logic en_ff;
  logic [2:0] awden_ff;
  logic [TRIG_N-1:0] trig_s1_ff, trig_s2_ff, trig_s3_ff;
  logic [11:0] data_s1_ff, data_s2_ff;
  logic [15:0] dr_ff;
  logic dvalid_ff;
  logic pwr_on_ff;
  logic pend_ff;
  logic mid_ff;
  logic [sarc_pkg::CH_W-1:0] seq_ch_ff;
  logic [7:0] ovs_cnt_ff;
  logic [sarc_pkg::ACC_W-1:0] acc_ff;
  logic [2:0] awd_trip;
  logic acc_wr, acc_rd;
  logic wr_isr, wr_ier, wr_cr, wr_cfg, wr_chsel, rd_dr;
  logic [2:0] wr_awd;
  logic mapped;
  logic sw_start, hw_edge, start_ev;
  logic launch, smp_done, conv_done;
  logic [5:0] first_ch, next_ch;
  logic last_ovs, seq_more;
  logic [11:0] raw;
  logic [ACC_W_L-1:0] ovs_sum;
  logic [15:0] result;
  logic need_off;
  logic trig_now, trig_prev;
  logic [8:0] ovs_last;

  // Lowest selected channel at or above a position
  function automatic logic [5:0] find_ch(input logic [18:0] m, input logic [4:0] from);
    logic [5:0] r;
    r = 6'h00;
    for (int i = sarc_pkg::CH_NUM - 1; i >= 0; i--) begin
      if (m[i] && i >= int'(from)) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // APB decode; the slave never stalls
  assign pready = 1'b1;
  assign acc_wr = psel && penable && pwrite;
  assign acc_rd = psel && penable && !pwrite;
  assign wr_isr = acc_wr && paddr == sarc_pkg::OFS_ISR;
  assign wr_ier = acc_wr && paddr == sarc_pkg::OFS_IER;
  assign wr_cr = acc_wr && paddr == sarc_pkg::OFS_CR;
  assign wr_cfg = acc_wr && paddr == sarc_pkg::OFS_CFG;
  assign wr_chsel = acc_wr && paddr == sarc_pkg::OFS_CHSEL;
  assign wr_awd[0] = acc_wr && paddr == sarc_pkg::OFS_AWD1;
  assign wr_awd[1] = acc_wr && paddr == sarc_pkg::OFS_AWD2;
  assign wr_awd[2] = acc_wr && paddr == sarc_pkg::OFS_AWD3;
  assign rd_dr = acc_rd && paddr == sarc_pkg::OFS_DR;
  assign sw_start = wr_cr && pwdata[sarc_pkg::CR_START];

  // Read mux and error answer for holes in the map
  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    unique case (paddr)
      sarc_pkg::OFS_ISR: prdata = 32'(isr_ff);
      sarc_pkg::OFS_IER: prdata = 32'(ier_ff);
      sarc_pkg::OFS_CR: prdata = {25'h0, awden_ff, 2'h0, state_ff != sarc_pkg::SARC_IDLE, en_ff};
      sarc_pkg::OFS_CFG: prdata = cfg_ff;
      sarc_pkg::OFS_CHSEL: prdata = 32'(chsel_ff);
      sarc_pkg::OFS_AWD1: prdata = thr_ff[0];
      sarc_pkg::OFS_AWD2: prdata = thr_ff[1];
      sarc_pkg::OFS_AWD3: prdata = thr_ff[2];
      sarc_pkg::OFS_DR: prdata = {16'h0000, dr_ff};
      sarc_pkg::OFS_SR: prdata = {26'h0, pwr_on_ff, dvalid_ff, mid_ff, pend_ff, state_ff};
      default: mapped = 1'b0;
    endcase
    if (!mapped) begin
      prdata = 32'h0000_0000;
    end
  end
  assign pslverr = psel && penable && !mapped;

  // Configuration registers; reserved channel positions never stick
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_ff <= '0;
      chsel_ff <= 19'h00000;
      en_ff <= 1'b0;
      awden_ff <= 3'h0;
      ier_ff <= '0;
    end else begin
      if (wr_cfg) begin
        cfg_ff <= {10'h000, pwdata[21:0]};
      end
      if (wr_chsel) begin
        chsel_ff <= pwdata[18:0] & sarc_pkg::CH_VALID;
      end
      if (wr_cr) begin
        en_ff <= pwdata[sarc_pkg::CR_EN];
        awden_ff <= pwdata[sarc_pkg::CR_AWDEN +: 3];
      end
      if (wr_ier) begin
        ier_ff <= pwdata[sarc_pkg::EVT_W-1:0];
      end
    end
  end

  // Watchdog thresholds, one word per watchdog
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < 3; k++) begin
        thr_ff[k] <= {4'h0, 12'hfff, 4'h0, 12'h000};
      end
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (wr_awd[k]) begin
          thr_ff[k] <= pwdata & 32'h0fff_0fff;
        end
      end
    end
  end

  // Pin inputs pass two flops; the third stage only feeds edge detection
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      trig_s1_ff <= '0;
      trig_s2_ff <= '0;
      trig_s3_ff <= '0;
      data_s1_ff <= 12'h000;
      data_s2_ff <= 12'h000;
    end else begin
      trig_s1_ff <= hw_trig;
      trig_s2_ff <= trig_s1_ff;
      trig_s3_ff <= trig_s2_ff;
      data_s1_ff <= ana_data;
      data_s2_ff <= data_s1_ff;
    end
  end

  // Trigger select 0 means software only; n picks line n-1
  always_comb begin
    trig_now = 1'b0;
    trig_prev = 1'b0;
    for (int t = 0; t < TRIG_N; t++) begin
      if (int'(cfg_ff.trig_sel) == t + 1) begin
        trig_now = trig_s2_ff[t];
        trig_prev = trig_s3_ff[t];
      end
    end
    unique case (cfg_ff.trig_pol)
      sarc_pkg::POL_RISE: hw_edge = trig_now && !trig_prev;
      sarc_pkg::POL_FALL: hw_edge = !trig_now && trig_prev;
      default: hw_edge = trig_now != trig_prev;
    endcase
  end
  assign start_ev = sw_start || hw_edge;

  // Sequence bookkeeping
  assign first_ch = find_ch(chsel_ff, 5'h00);
  assign next_ch = find_ch(chsel_ff, 5'(seq_ch_ff + 5'h01));
  assign ovs_last = (9'h002 << cfg_ff.ovs_ratio) - 9'h001;
  assign last_ovs = !cfg_ff.ovs_en || {1'b0, ovs_cnt_ff} == ovs_last;
  assign seq_more = cfg_ff.scan && next_ch[5];
  assign need_off = cfg_ff.autoff || stop_mode;

  // Phase sequencer: power-up, sampling, conversion
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    launch = 1'b0;
    smp_done = 1'b0;
    conv_done = 1'b0;
    unique case (state_ff)
      sarc_pkg::SARC_IDLE: begin
        // Wait mode holds off while a result is unread
        if (en_ff && first_ch[5] && (pend_ff || start_ev)
            && !(cfg_ff.waitm && dvalid_ff)) begin
          launch = 1'b1;
          if (pwr_on_ff) begin
            nxt_state = sarc_pkg::SARC_SMP;
            nxt_cnt = CNT_W_L'(sarc_pkg::SMP_CYC - 1);
          end else begin
            nxt_state = sarc_pkg::SARC_PWRUP;
            nxt_cnt = CNT_W_L'(sarc_pkg::PWRUP_CYC - 1);
          end
        end
      end
      sarc_pkg::SARC_PWRUP: begin
        if (cnt_ff == '0) begin
          nxt_state = sarc_pkg::SARC_SMP;
          nxt_cnt = CNT_W_L'(sarc_pkg::SMP_CYC - 1);
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      sarc_pkg::SARC_SMP: begin
        if (cnt_ff == '0) begin
          smp_done = 1'b1;
          nxt_state = sarc_pkg::SARC_CONV;
          nxt_cnt = sarc_pkg::sarc_conv_cyc(cfg_ff.res) - 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      sarc_pkg::SARC_CONV: begin
        if (cnt_ff == '0) begin
          conv_done = 1'b1;
          nxt_state = sarc_pkg::SARC_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
    endcase
    if (!en_ff) begin
      nxt_state = sarc_pkg::SARC_IDLE;
    end
  end

  // Phase state and its down counter
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= sarc_pkg::SARC_IDLE;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Channel stepping, discontinuous parking and continuous rearm
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seq_ch_ff <= '0;
      pend_ff <= 1'b0;
      mid_ff <= 1'b0;
    end else if (!en_ff) begin
      pend_ff <= 1'b0;
      mid_ff <= 1'b0;
    end else if (launch) begin
      pend_ff <= 1'b0;
      if (!pend_ff && !mid_ff) begin
        seq_ch_ff <= first_ch[4:0];
      end
    end else if (conv_done) begin
      if (!last_ovs) begin
        pend_ff <= 1'b1;
      end else if (seq_more) begin
        seq_ch_ff <= next_ch[4:0];
        mid_ff <= cfg_ff.disc;
        pend_ff <= !cfg_ff.disc;
      end else begin
        seq_ch_ff <= first_ch[4:0];
        mid_ff <= 1'b0;
        pend_ff <= cfg_ff.cont;
      end
    end
  end

  // Analog core power; dropped in idle under auto-off or stop
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pwr_on_ff <= 1'b0;
    end else if (state_ff == sarc_pkg::SARC_PWRUP && cnt_ff == '0) begin
      pwr_on_ff <= 1'b1;
    end else if (state_ff == sarc_pkg::SARC_IDLE && !launch && (need_off || !en_ff)) begin
      pwr_on_ff <= 1'b0;
    end
  end

  // Raw value masked to the chosen width, then averaged or aligned
  assign raw = data_s2_ff & (sarc_pkg::RAW_FULL >> {cfg_ff.res, 1'b0});
  assign ovs_sum = acc_ff + ACC_W_L'(raw);
  always_comb begin
    if (cfg_ff.ovs_en) begin
      result = 16'(ovs_sum >> cfg_ff.ovs_shift);
    end else if (cfg_ff.align) begin
      result = {4'h0, raw} << (5'd16 - sarc_pkg::sarc_bits(cfg_ff.res));
    end else begin
      result = {4'h0, raw};
    end
  end

  // Oversampling accumulator
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      acc_ff <= '0;
      ovs_cnt_ff <= 8'h00;
    end else if (!en_ff) begin
      acc_ff <= '0;
      ovs_cnt_ff <= 8'h00;
    end else if (conv_done) begin
      acc_ff <= last_ovs ? '0 : ovs_sum;
      ovs_cnt_ff <= last_ovs ? 8'h00 : ovs_cnt_ff + 8'h01;
    end
  end

  // Data register; a fresh result wins over a same-cycle read
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dr_ff <= 16'h0000;
      dvalid_ff <= 1'b0;
    end else if (conv_done && last_ovs) begin
      dr_ff <= result;
      dvalid_ff <= 1'b1;
    end else if (rd_dr || dma_ack) begin
      dvalid_ff <= 1'b0;
    end
  end

  // Three watchdogs share the raw value of every conversion
  for (genvar w = 0; w < 3; w++) begin : g_awd
    sarc_wdog u_wdog (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .en(awden_ff[w]),
      .stb(conv_done),
      .val(raw),
      .thr(thr_ff[w]),
      .trip(awd_trip[w])
    );
  end

  // Event sources
  always_comb begin
    evt_set = '0;
    evt_set.eosmp = smp_done;
    evt_set.eoc = conv_done && last_ovs;
    evt_set.eos = conv_done && last_ovs && !seq_more;
    evt_set.ovr = conv_done && last_ovs && dvalid_ff && !rd_dr && !dma_ack;
    evt_set.awd1 = awd_trip[0];
    evt_set.awd2 = awd_trip[1];
    evt_set.awd3 = awd_trip[2];
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      isr_ff <= '0;
    end else begin
      isr_ff <= (isr_ff & ~(wr_isr ? pwdata[sarc_pkg::EVT_W-1:0] : '0)) | evt_set;
    end
  end

  assign irq = |(isr_ff & ier_ff);
  assign wakeup = stop_mode && irq;

  // DMA moves each result out; the request holds until acknowledged or the data register is read
  assign dma_req = cfg_ff.dma_en && dvalid_ff;
  assign dma_data = dr_ff;

  // Analog core controls decoded from state flops
  assign ana.pwr = pwr_on_ff || state_ff == sarc_pkg::SARC_PWRUP;
  assign ana.sample = state_ff == sarc_pkg::SARC_SMP;
  assign ana.conv = state_ff == sarc_pkg::SARC_CONV;
  assign ana.res = cfg_ff.res;
  assign ana.chan = seq_ch_ff;
endmodule

// File: verif/sarc_top_asserts.sv
// Port-level concurrent checks of the converter sequencer
`timescale 1ns/1ps
module sarc_asserts (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire sarc_pkg::sarc_ana_t ana,
  input wire logic stop_mode,
  input wire logic irq,
  input wire logic wakeup,
  input wire logic dma_req,
  input wire logic dma_ack,
  input wire logic [15:0] dma_data
);
  logic [7:0] cnt_ff;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // Length of the running conversion phase, zero between phases
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) cnt_ff <= 8'h00;
    else cnt_ff <= ana.conv ? cnt_ff + 8'h01 : 8'h00;
  end

  a_conv_len: assert property ($fell(ana.conv) |->
    int'(cnt_ff) == int'(sarc_pkg::CONV12_CYC) * (12 - 2 * int'($past(ana.res))) / 12)
    else $error("conversion phase length off");
  a_chan_ok: assert property (ana.sample |-> sarc_pkg::CH_VALID[ana.chan])
    else $error("reserved channel sampled");
  a_pwr_conv: assert property ((ana.sample || ana.conv) |-> ana.pwr)
    else $error("analog core off while converting");
  a_smp_len: assert property ($rose(ana.sample) |->
    ana.sample [*4] ##1 (ana.conv && !ana.sample))
    else $error("sampling phase length off");
  a_sel_hold: assert property (ana.conv |-> $stable(ana.chan) && $stable(ana.res))
    else $error("channel or resolution moved mid conversion");
  a_wake_and: assert property (wakeup == (stop_mode && irq))
    else $error("wakeup does not follow irq in stop");
  a_dma_hold: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_data))
    else $error("dma request dropped or data moved");
  a_dma_drop: assert property (dma_ack |=> !dma_req)
    else $error("dma request stays after ack");

  // Main scenarios reached
  c_conv6: cover property ($rose(ana.conv) && ana.res == sarc_pkg::RES_6);
  c_dma: cover property (dma_ack);
  c_wake: cover property ($rose(wakeup));
endmodule

// File: verif/sarc_ana_model.sv
// Analog input and DMA partner of the converter sequencer
`timescale 1ns/1ps
module sarc_ana_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire sarc_pkg::sarc_ana_t ana,
  input wire logic slow,
  output logic [11:0] ana_data,
  input wire logic dma_req,
  output logic dma_ack,
  input wire logic [15:0] dma_data
);
  logic [15:0] got_q[$];
  int wait_n;
  initial ana_data = 12'h5a5;

  // Channel level held while sampling or converting; toggles otherwise so stale data shows
  always @(posedge clk_sys) begin
    if (ana.pwr && (ana.sample || ana.conv)) ana_data <= 12'(int'(ana.chan) * 209 + 291);
    else ana_data <= ~ana_data;
  end

  // One ack per result, prompt or after a short stall
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dma_ack <= 1'b0;
      wait_n <= 0;
    end else begin
      dma_ack <= 1'b0;
      if (dma_req && !dma_ack) begin
        if (wait_n >= (slow ? 6 : 0)) begin
          dma_ack <= 1'b1;
          got_q.push_back(dma_data);
          wait_n <= 0;
        end else wait_n <= wait_n + 1;
      end
    end
  end
endmodule

// File: verif/sar_adc_sequencer_control_tb.sv
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_control_tb;
  logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, er;
  logic stop_mode, dma_req, dma_ack, irq, wakeup, slow;
  logic [7:0] paddr, lf;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] hw_trig;
  logic [11:0] ana_data;
  logic [15:0] dma_data;
  logic [18:0] mask;
  sarc_pkg::sarc_ana_t ana;
  int bad_count, n_checks, done_n, cur, last, d;
  int ch_q[$];

  sarc_top dut (.clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_trig(hw_trig), .stop_mode(stop_mode), .ana_data(ana_data),
    .ana(ana), .dma_req(dma_req), .dma_ack(dma_ack), .dma_data(dma_data), .irq(irq),
    .wakeup(wakeup));
  sarc_ana_model pm (.clk_sys(clk_sys), .resetn(resetn), .ana(ana), .slow(slow),
    .ana_data(ana_data), .dma_req(dma_req), .dma_ack(dma_ack), .dma_data(dma_data));

  // Clock, 10 ns period
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Reference: conversion lengths and completions seen at the analog port
  always @(posedge clk_sys) begin
    if (ana.conv) cur++;
    else if (cur != 0) begin
      last = cur;
      cur = 0;
      done_n++;
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [11:0] raw(input int c);
    return 12'(c * 209 + 291);
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      bad_count++;
    end
  endtask

  // APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= v;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_done(input int n);
    for (int k = 0; k < 3000 && done_n < n; k++) @(negedge clk_sys);
    chk(32'(done_n), 32'(n));
  endtask

  // Software start with the given control word, then let flags settle
  task automatic conv1(input logic [31:0] cr);
    d = done_n;
    apb(1'b1, sarc_pkg::OFS_CR, cr);
    wait_done(d + 1);
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Hang guard, far beyond the expected run
  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end

  initial begin
    {resetn, psel, penable, pwrite, stop_mode, slow} <= 6'h00;
    {paddr, pwdata, hw_trig} <= '0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    // Reset values, unmapped access, sticky channel bits
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, (i > 4 && i < 8) ? 32'h0fff0000 : 32'h0);
    end
    apb(1'b0, 8'h28, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, sarc_pkg::OFS_CHSEL, 32'hffffffff);
    apb(1'b0, sarc_pkg::OFS_CHSEL, 32'h0);
    chk(rd, 32'h0000707f);
    // Continuous scan of random channels through DMA
    lf = 8'h4f;
    repeat (3) lf = lfsr(lf);
    mask = 19'(lf[6:0]) | 19'h02000;
    for (int c = 0; c < 19; c++) if (mask[c]) ch_q.push_back(c);
    slow <= lf[7];
    apb(1'b1, sarc_pkg::OFS_IER, 32'h7f);
    apb(1'b1, sarc_pkg::OFS_CHSEL, 32'(mask));
    apb(1'b1, sarc_pkg::OFS_CFG, 32'h2018);
    apb(1'b1, sarc_pkg::OFS_CR, 32'h1);
    apb(1'b1, sarc_pkg::OFS_CR, 32'h3);
    for (int k = 0; k < 4000 && pm.got_q.size() < 2 * ch_q.size(); k++) @(negedge clk_sys);
    apb(1'b1, sarc_pkg::OFS_CFG, 32'h2010);
    for (int k = 0; k < 300 && rd[3:0] != 4'h0; k++) apb(1'b0, sarc_pkg::OFS_SR, 32'h0);
    repeat (10) @(posedge clk_sys);
    chk(32'(pm.got_q.size() >= 2 * ch_q.size()), 32'h1);
    chk({28'(pm.got_q.size() % ch_q.size()), rd[3:0]}, 32'h0);
    foreach (pm.got_q[i]) chk(32'(pm.got_q[i]), 32'(raw(ch_q[i % ch_q.size()])));
    apb(1'b0, sarc_pkg::OFS_ISR, 32'h0);
    chk(32'({rd[2], irq}), 32'h3);
    stop_mode <= 1'b1;
    @(negedge clk_sys);
    chk(32'(wakeup), 32'h1);
    @(posedge clk_sys);
    stop_mode <= 1'b0;
    apb(1'b1, sarc_pkg::OFS_ISR, 32'h7f);
    apb(1'b0, sarc_pkg::OFS_ISR, 32'h0);
    chk({rd[30:0], irq}, 32'h0);
    // Each resolution, one conversion per start
    apb(1'b1, sarc_pkg::OFS_CHSEL, 32'h4);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, sarc_pkg::OFS_CFG, 32'(r));
      conv1(32'h3);
      chk(32'(last), 32'(40 * (12 - 2 * r) / 12));
      apb(1'b0, sarc_pkg::OFS_DR, 32'h0);
      if (r == 0) chk(rd, 32'(raw(2)));
    end
    repeat (100) @(negedge clk_sys);
    chk(32'(done_n), 32'(d + 1));
    // Left alignment, then overrun of an unread result
    apb(1'b1, sarc_pkg::OFS_CFG, 32'h4);
    conv1(32'h3);
    apb(1'b0, sarc_pkg::OFS_DR, 32'h0);
    chk(rd, {16'h0, raw(2), 4'h0});
    apb(1'b1, sarc_pkg::OFS_CFG, 32'h0);
    conv1(32'h3);
    conv1(32'h3);
    apb(1'b0, sarc_pkg::OFS_ISR, 32'h0);
    chk(32'(rd[3]), 32'h1);
    apb(1'b0, sarc_pkg::OFS_DR, 32'h0);
    apb(1'b1, sarc_pkg::OFS_ISR, 32'h7f);
    // Wait mode holds continuous conversions until the result is read
    apb(1'b1, sarc_pkg::OFS_CFG, 32'h48);
    conv1(32'h3);
    repeat (200) @(negedge clk_sys);
    chk(32'(done_n), 32'(d + 1));
    apb(1'b0, sarc_pkg::OFS_DR, 32'h0);
    apb(1'b1, sarc_pkg::OFS_CFG, 32'h40);
    wait_done(d + 2);
    repeat (3) @(posedge clk_sys);
    apb(1'b0, sarc_pkg::OFS_DR, 32'h0);
    apb(1'b0, sarc_pkg::OFS_ISR, 32'h0);
    chk(32'(rd[3]), 32'h0);
    // Autonomous falling-edge trigger in stop with auto-off and DMA
    apb(1'b1, sarc_pkg::OFS_CFG, 32'h2980);
    d = done_n;
    stop_mode <= 1'b1;
    hw_trig <= {lf[3:1], 1'b1};
    repeat (100) @(negedge clk_sys);
    chk({ana.pwr, 31'(done_n)}, 32'(d));
    @(posedge clk_sys);
    hw_trig <= {lf[6:4], 1'b0};
    wait_done(d + 1);
    repeat (10) @(negedge clk_sys);
    chk({ana.pwr, 15'h0, pm.got_q[$]}, 32'(raw(2)));
    @(posedge clk_sys);
    stop_mode <= 1'b0;
    // Watchdog 1 window below the input, watchdog 2 around it
    apb(1'b1, sarc_pkg::OFS_CFG, 32'h0);
    apb(1'b1, sarc_pkg::OFS_AWD1, {4'h0, raw(2) - 12'h001, 16'h0000});
    apb(1'b1, sarc_pkg::OFS_ISR, 32'h7f);
    conv1(32'h33);
    apb(1'b0, sarc_pkg::OFS_ISR, 32'h0);
    chk(32'(rd[5:4]), 32'h1);
    apb(1'b0, sarc_pkg::OFS_DR, 32'h0);
    // Discontinuous scan: each start converts only the next channel
    apb(1'b1, sarc_pkg::OFS_CHSEL, 32'h2004);
    apb(1'b1, sarc_pkg::OFS_CFG, 32'h30);
    for (int c = 2; c < 14; c += 11) begin
      conv1(32'h3);
      repeat (60) @(negedge clk_sys);
      apb(1'b0, sarc_pkg::OFS_DR, 32'h0);
      chk({rd[15:0], 16'(done_n - d)}, {4'h0, raw(c), 16'h0001});
    end
    // Oversampling, four conversions summed, then halved
    apb(1'b1, sarc_pkg::OFS_CFG, 32'h4c000);
    d = done_n;
    apb(1'b1, sarc_pkg::OFS_CR, 32'h3);
    wait_done(d + 4);
    repeat (3) @(posedge clk_sys);
    apb(1'b0, sarc_pkg::OFS_DR, 32'h0);
    chk(rd, 32'(raw(2)) * 2);
    summarize();
  end
endmodule

bind sarc_top sarc_asserts u_chk (.clk_sys(clk_sys), .resetn(resetn), .ana(ana),
  .stop_mode(stop_mode), .irq(irq), .wakeup(wakeup), .dma_req(dma_req),
  .dma_ack(dma_ack), .dma_data(dma_data));
